// File: include/adc_seq_defs.vh
// What this block does
// R1: reading the result high byte clears the conversion-done flag (bit 7)
// R2: a finish while the flag is still set leaves it set
// R3: start bit launches a sequence only with trigger select 11 and idle
// R4: start bit reads one while the sequence runs, zero after
// R5: trigger select 01 runs sequences back to back; field resets to 11
// R6: rng control 00 runs normally, thirteen unrolled steps; reset value
// R7: rng control 01 steps once, then the field returns to 00 by itself
// R8: rng control 11 stops the generator; 10 is reserved
// R9: software always writes 11 into control one bits 1:0
// R10: reference select decodes internal, input seven, supply, differential 6-7
// R11: decimation select gives 64/7, 128/9, 256/10, 512/12; resets to 01
// R12: last channel up to 7 runs single-ended inputs 0 to last
// R13: last channel 8 to 11 runs differential pairs up to last pair
// R14: last channel 12 to 15 performs one single conversion
// R15: reading last channel returns held result channel plus one
// R16: result high byte is read-only, resets zero, shows result bits 13:6
// R17: conversion-done flag sets when a conversion ends
// R18: triggers: pin rising edge, end of sequence, timer compare, start bit
// R19: channels with disabled inputs are skipped; pairs need both pins
// R20: trigger code 00 is pin rising edge, 10 is timer compare
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
`define ADDR_CTRL_ONE     8'hb4
`define ADDR_CTRL_TWO     8'hb5
`define ADDR_RESULT_HIGH  8'hbb
`define CTRL_ONE_RESET    8'h33
`define CTRL_TWO_RESET    8'h10
`define RESULT_HIGH_RESET 8'h00
`define BIT_DONE          7
`define BIT_START         6
`define TRIG_PIN          2'h0
`define TRIG_FULL         2'h1
`define TRIG_TIMER        2'h2
`define TRIG_SOFT         2'h3
`define RNG_NORMAL        2'h0
`define RNG_STEP_ONCE     2'h1
`define RNG_STOP          2'h3
`define RNG_SEED          16'hffff
`define RNG_UNROLL        13
`define DONE_RESET        1'b0
`define START_RESET       1'b0
`define TRIG_RESET        2'h3
`define RNG_RESET         2'h0
`define LOW_RESET         2'h3
`define SEQUENCE_REFERENCE_SELECT_RESET        2'h0
`define SEQUENCE_DECIMATION_SELECT_RESET        2'h1
`define LAST_CH_RESET     4'h0
`define TRIG_FIELD        5:4
`define RNG_FIELD         3:2
`define LOW_FIELD         1:0
`define SEQUENCE_REFERENCE_SELECT_FIELD        7:6
`define SEQUENCE_DECIMATION_SELECT_FIELD        5:4
`define LAST_CH_FIELD     3:0
`define SETTLE_CYCLES     16
`endif

// File: verilog/adc_sequence_control_regs.v
`timescale 1ns/1ps
`include "adc_seq_defs.vh"
module adc_sequence_control_regs (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire [7:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr_en,
    input  wire        rd_en,
    input  wire        external_trigger_pin,
    input  wire        timer_compare,
    input  wire [7:0]  input_enable,
    input  wire        conv_done,
    input  wire [13:0] conv_result,
    output reg  [7:0]  rdata,
    output reg         conv_start,
    output reg  [3:0]  conv_channel,
    output reg  [1:0]  conv_reference,
    output reg  [1:0]  conv_decimation,
    output reg  [15:0] rng_value
);
    // ==========================================================
    // state and registers
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CONV = 3'b010;
    localparam [2:0] ST_NEXT = 3'b100;
    reg [2:0]  state_q;
    reg        done_q;
    reg        start_q;
    reg [1:0]  trig_q;
    reg [1:0]  rng_ctl_q;
    reg [1:0]  low_q;
    reg [1:0]  sequence_reference_select_q;
    reg [1:0]  sequence_decimation_select_q;
    reg [3:0]  last_ch_q;
    reg [3:0]  held_ch_q;
    reg [7:0]  result_high_q;
    reg        pin_prev_q;
    reg [3:0]  cur_ch_q;
    integer    k;
    reg [15:0] rng_d;

    function [15:0] lfsr_step;
        input [15:0] v;
        begin
            lfsr_step = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
        end
    endfunction

    // pair channels need both pins, single ends need their own
    function chan_ok;
        input [3:0] ch;
        input [7:0] en;
        begin
            if (ch[3] == 1'b0)
                chan_ok = en[ch[2:0]];
            else if (ch[3:2] == 2'b10)
                chan_ok = en[{ch[1:0], 1'b0}] & en[{ch[1:0], 1'b1}];
            else
                chan_ok = 1'b1;
        end
    endfunction

    // first channel of a sequence, from last-channel code
    function [3:0] first_ch;
        input [3:0] last;
        begin
            if (last[3] == 1'b0)
                first_ch = 4'h0; // [R12]
            else if (last[3:2] == 2'b10)
                first_ch = 4'h8; // [R13]
            else
                first_ch = last; // [R14]
        end
    endfunction

    // next channel in a sequence; wraps like the four-bit field
    function [3:0] chan_after;
        input [3:0] ch;
        begin
            chan_after = ch + 4'h1;
        end
    endfunction

    // ==========================================================
    // trigger selection
    wire pin_rise = external_trigger_pin & ~pin_prev_q;
    reg  trig_fire;
    always @* begin
        case (trig_q) // [R18] [R20]
            `TRIG_PIN:   trig_fire = pin_rise;
            `TRIG_FULL:  trig_fire = 1'b1; // [R5]
            `TRIG_TIMER: trig_fire = timer_compare;
            default:     trig_fire = start_q; // [R3]
        endcase
    end
    wire idle   = state_q == ST_IDLE;
    wire last_c = (cur_ch_q == last_ch_q) || last_ch_q[3:2] == 2'b11;
    wire wr1    = wr_en && addr == `ADDR_CTRL_ONE;
    wire wr2    = wr_en && addr == `ADDR_CTRL_TWO;
    wire rd_hi  = rd_en && addr == `ADDR_RESULT_HIGH;

    // ==========================================================
    // sequencer
    always @(posedge sys_clk) begin
        if (srst) begin
            state_q      <= ST_IDLE;
            cur_ch_q     <= 4'h0;
            conv_start   <= 1'b0;
            conv_channel <= 4'h0;
            pin_prev_q   <= 1'b0;
        end else begin
            pin_prev_q <= external_trigger_pin;
            conv_start <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (trig_fire) begin // [R3]
                        cur_ch_q <= first_ch(last_ch_q);
                        state_q  <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    // skipped channel costs one cycle, no conversion
                    if (chan_ok(cur_ch_q, input_enable)) begin // [R19]
                        conv_channel <= cur_ch_q;
                        conv_start   <= 1'b1;
                        state_q      <= ST_CONV;
                    end else if (last_c) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cur_ch_q <= chan_after(cur_ch_q);
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        if (last_c) begin
                            state_q <= ST_IDLE;
                        end else begin
                            cur_ch_q <= chan_after(cur_ch_q);
                            state_q  <= ST_NEXT;
                        end
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // last channel either converted or skipped ends the sequence
    wire seq_end = (state_q == ST_CONV && conv_done && last_c)
                || (state_q == ST_NEXT && last_c
                    && !chan_ok(cur_ch_q, input_enable));
    wire conv_end = conv_done && (state_q == ST_CONV);

    // ==========================================================
    // conversion-done flag
    reg        done_d;

    always @* begin
        done_d = done_q;
        // set wins over the read clear, so a result is never lost
        if (conv_end)
            done_d = 1'b1; // [R17] [R2]
        else if (rd_hi)
            done_d = 1'b0; // [R1]
    end

    always @(posedge sys_clk) begin
        if (srst)
            done_q <= `DONE_RESET;
        else
            done_q <= done_d;
    end

    // ==========================================================
    // result high byte and channel read-back
    reg [7:0]  result_high_d;
    reg [3:0]  held_ch_d;

    always @* begin
        result_high_d = result_high_q;
        held_ch_d     = held_ch_q;
        // channel plus one, as software expects on read-back
        if (conv_end) begin
            result_high_d = conv_result[13:6]; // [R16]
            held_ch_d     = chan_after(cur_ch_q); // [R15]
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            result_high_q <= `RESULT_HIGH_RESET; // [R16]
            held_ch_q     <= `LAST_CH_RESET;
        end else begin
            result_high_q <= result_high_d;
            held_ch_q     <= held_ch_d;
        end
    end

    // ==========================================================
    // control one fields
    reg [1:0]  trig_d;
    reg [1:0]  rng_ctl_d;
    reg [1:0]  low_d;

    always @* begin
        trig_d    = trig_q;
        rng_ctl_d = rng_ctl_q;
        low_d     = low_q;
        if (wr1) begin
            trig_d    = wdata[`TRIG_FIELD];
            rng_ctl_d = wdata[`RNG_FIELD];
            // reserved bits kept as written, not forced
            low_d     = wdata[`LOW_FIELD]; // [R9]
        end else if (rng_ctl_q == `RNG_STEP_ONCE) begin
            // the single step takes one cycle, then back to normal
            rng_ctl_d = `RNG_NORMAL; // [R7]
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            trig_q    <= `TRIG_RESET; // [R5]
            rng_ctl_q <= `RNG_RESET; // [R6]
            low_q     <= `LOW_RESET;
        end else begin
            trig_q    <= trig_d;
            rng_ctl_q <= rng_ctl_d;
            low_q     <= low_d;
        end
    end

    // ==========================================================
    // software start bit
    reg        start_d;
    wire       soft_go = wr1 && wdata[`BIT_START] && idle
                      && (wdata[`TRIG_FIELD] == `TRIG_SOFT);

    always @* begin
        start_d = start_q;
        // a start written while busy or with another select is dropped
        if (soft_go)
            start_d = 1'b1; // [R3]
        else if (seq_end)
            start_d = 1'b0; // [R4]
    end

    always @(posedge sys_clk) begin
        if (srst)
            start_q <= `START_RESET;
        else
            start_q <= start_d;
    end

    // ==========================================================
    // control two fields
    reg [1:0]  sequence_reference_select_d;
    reg [1:0]  sequence_decimation_select_d;
    reg [3:0]  last_ch_d;

    always @* begin
        sequence_reference_select_d    = sequence_reference_select_q;
        sequence_decimation_select_d    = sequence_decimation_select_q;
        last_ch_d = last_ch_q;
        // no interlock: a change mid-sequence is taken at once
        if (wr2) begin
            sequence_reference_select_d    = wdata[`SEQUENCE_REFERENCE_SELECT_FIELD];
            sequence_decimation_select_d    = wdata[`SEQUENCE_DECIMATION_SELECT_FIELD];
            last_ch_d = wdata[`LAST_CH_FIELD];
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            sequence_reference_select_q    <= `SEQUENCE_REFERENCE_SELECT_RESET; // [R10]
            sequence_decimation_select_q    <= `SEQUENCE_DECIMATION_SELECT_RESET; // [R11]
            last_ch_q <= `LAST_CH_RESET;
        end else begin
            sequence_reference_select_q    <= sequence_reference_select_d;
            sequence_decimation_select_q    <= sequence_decimation_select_d;
            last_ch_q <= last_ch_d;
        end
    end

    // ==========================================================
    // settings handed to the converter
    // registered copies, so the converter sees clean fields
    always @(posedge sys_clk) begin
        if (srst) begin
            conv_reference  <= `SEQUENCE_REFERENCE_SELECT_RESET;
            conv_decimation <= `SEQUENCE_DECIMATION_SELECT_RESET;
        end else begin
            conv_reference  <= sequence_reference_select_q; // [R10]
            conv_decimation <= sequence_decimation_select_q; // [R11]
        end
    end

    // ==========================================================
    // random number generator
    always @* begin
        rng_d = rng_value;
        case (rng_ctl_q)
            `RNG_NORMAL: begin
                for (k = 0; k < `RNG_UNROLL; k = k + 1)
                    rng_d = lfsr_step(rng_d); // [R6]
            end
            `RNG_STEP_ONCE: rng_d = lfsr_step(rng_value); // [R7]
            // reserved code 10 is treated as stopped
            default: rng_d = rng_value; // [R8]
        endcase
    end

    // thirteen steps per clock: deep logic, but fresh on every read
    always @(posedge sys_clk) begin
        if (srst)
            rng_value <= `RNG_SEED;
        else
            rng_value <= rng_d;
    end

    // ==========================================================
    // read port, data the cycle after the strobe and zero otherwise
    // mux first, then one flop so rdata leaves a register
    reg [7:0]  rdata_d;

    always @* begin
        rdata_d = 8'h00;
        if (rd_en) begin
            if (addr == `ADDR_CTRL_ONE)
                rdata_d = {done_q, start_q, trig_q, rng_ctl_q, low_q};
            else if (addr == `ADDR_CTRL_TWO)
                rdata_d = {sequence_reference_select_q, sequence_decimation_select_q, held_ch_q}; // [R15]
            else if (addr == `ADDR_RESULT_HIGH)
                rdata_d = result_high_q; // [R16]
            else
                rdata_d = 8'h00;
        end
    end

    always @(posedge sys_clk) begin
        if (srst)
            rdata <= 8'h00;
        else
            rdata <= rdata_d;
    end
endmodule

// File: dv/adc_seq_asserts.sv
`timescale 1ns/1ps
`include "adc_seq_defs.vh"
module adc_seq_checker (
    input wire        sys_clk,
    input wire        srst,
    input wire [7:0]  addr,
    input wire [7:0]  wdata,
    input wire        wr_en,
    input wire        rd_en,
    input wire        conv_done,
    input wire        conv_start,
    input wire [7:0]  rdata,
    input wire [1:0]  conv_reference,
    input wire [1:0]  conv_decimation,
    input wire [15:0] rng_value
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire rd1 = rd_en && addr == `ADDR_CTRL_ONE;
    wire rd2 = rd_en && addr == `ADDR_CTRL_TWO;
    wire rdh = rd_en && addr == `ADDR_RESULT_HIGH;
    // select 11 in force: only the start bit can have launched work
    reg  soft_q;
    always @(posedge sys_clk)
        if (srst)
            soft_q <= 1'b1;
        else if (wr_en && addr == `ADDR_CTRL_ONE)
            soft_q <= wdata[`TRIG_FIELD] == `TRIG_SOFT;
    // ========================================
    // register side
    reset_vals_a: assert property (disable iff (1'b0)
        srst |=> conv_decimation == 2'h1 && conv_reference == 2'h0)
        else $error("reset values wrong");
    done_clear_a: assert property (
        (rdh && !conv_done) ##1 !conv_done ##1 (rd1 && !conv_done)
        |=> !rdata[`BIT_DONE]) else $error("done flag not cleared");
    ref_read_a: assert property (
        rd2 && !$past(wr_en) |=> rdata[7:6] == conv_reference)
        else $error("reference copy differs");
    dec_read_a: assert property (
        rd2 && !$past(wr_en) |=> rdata[5:4] == conv_decimation)
        else $error("decimation copy differs");
    unmapped_zero_a: assert property (
        rd_en && !rd1 && !rd2 && !rdh |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    // ========================================
    // sequencer side
    start_pulse_a: assert property (
        conv_start |=> !conv_start) else $error("start pulse too long");
    start_busy_a: assert property (
        (conv_start && !conv_done && soft_q) ##1 (rd1 && !conv_done)
        |=> rdata[`BIT_START]) else $error("start bit low while busy");
    rng_stop_a: assert property (
        rd1 ##1 rdata[3:2] == 2'h3 |-> $stable(rng_value))
        else $error("stopped generator moved");
    cover property (conv_start);
    cover property (rdh ##2 rd1);
    cover property (rd1 ##1 rdata[3:2] == 2'h3);
endmodule
bind adc_sequence_control_regs adc_seq_checker chk_i (.sys_clk, .srst,
    .addr, .wdata, .wr_en, .rd_en, .conv_done, .conv_start, .rdata,
    .conv_reference, .conv_decimation, .rng_value);

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "adc_seq_defs.vh"
module testbench;
    reg        sys_clk, srst, wr_en, rd_en, pin, tmr, conv_done;
    reg [7:0]  addr, wdata, en;
    reg [13:0] conv_result;
    wire [7:0] rdata;
    wire       conv_start;
    wire [3:0] conv_channel;
    wire [15:0] rng_value;
    reg [15:0] r;
    integer    miscompares, n_compared, i, j, n;
    adc_sequence_control_regs uut (.sys_clk(sys_clk), .srst(srst),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .external_trigger_pin(pin), .timer_compare(tmr),
        .input_enable(en), .conv_done(conv_done),
        .conv_result(conv_result), .rdata(rdata), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_reference(),
        .conv_decimation(), .rng_value(rng_value));
    // generator model, taps 16 14 13 11
    function [15:0] lfsr1(input [15:0] v);
        lfsr1 = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask
    task chk(input [7:0] got, exp, m);
        begin
            n_compared = n_compared + 1;
            if ((got & m) !== exp) begin
                miscompares = miscompares + 1;
                $display("Error %0t: got %h want %h", $time, got & m, exp);
            end
        end
    endtask
    task wr(input [7:0] a, d);
        begin
            @(posedge sys_clk);
            addr <= a;
            wdata <= d;
            wr_en <= 1'b1;
            @(posedge sys_clk);
            wr_en <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, e, m);
        begin
            @(posedge sys_clk);
            addr <= a;
            rd_en <= 1'b1;
            @(posedge sys_clk);
            rd_en <= 1'b0;
            #1 chk(rdata, e, m);
        end
    endtask
    // waits bounded for the start pulse, then plays the converter
    task conv(input [3:0] c, input s);
        begin
            n = 0;
            #1;
            while (conv_start !== 1'b1 && n < 60) begin
                @(posedge sys_clk);
                #1 n = n + 1;
            end
            chk({7'h0, n < 60}, 8'h01, 8'h01);
            chk({4'h0, conv_channel}, {4'h0, c}, 8'h0f);
            rd(`ADDR_CTRL_ONE, {1'b0, s, 6'h0}, 8'h40);
            @(posedge sys_clk);
            conv_done <= 1'b1;
            conv_result <= {c, 10'h2a5};
            @(posedge sys_clk);
            conv_done <= 1'b0;
        end
    endtask
    task run(input [3:0] f, l, input s);
        begin
            for (j = f; j <= l; j = j + 1)
                if (j > 7 || en[j]) conv(j[3:0], s);
            repeat (3) @(posedge sys_clk);
            rd(`ADDR_CTRL_ONE, 8'h80, 8'hc0);
            rd(`ADDR_CTRL_TWO, {4'h0, l + 4'h1}, 8'h0f);
            rd(`ADDR_RESULT_HIGH, {l, 4'ha}, 8'hff);
            rd(`ADDR_CTRL_ONE, 8'h00, 8'h80);
            $display("sequence to %0d done", l);
        end
    endtask
    initial begin
        #100000;
        miscompares = miscompares + 1;
        summarize;
    end
    initial begin
        {srst, wr_en, rd_en, pin, tmr, conv_done} = 6'b100000;
        {addr, wdata, conv_result, en} = {30'h0, 8'hff};
        miscompares = 0;
        n_compared = 0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        rd(`ADDR_CTRL_ONE, `CTRL_ONE_RESET, 8'hff);
        rd(`ADDR_CTRL_TWO, `CTRL_TWO_RESET, 8'hff);
        rd(`ADDR_RESULT_HIGH, 8'h00, 8'hff);
        rd(8'hb6, 8'h00, 8'hff);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`ADDR_CTRL_TWO, {i[1:0], i[1:0], 4'h0});
            rd(`ADDR_CTRL_TWO, {i[1:0], i[1:0], 4'h0}, 8'hf0);
        end
        wr(`ADDR_CTRL_ONE, 8'h43);
        rd(`ADDR_CTRL_ONE, 8'h00, 8'h40);
        wr(`ADDR_CTRL_ONE, 8'h3f);
        rd(`ADDR_CTRL_ONE, 8'h3f, 8'hff);
        r = rng_value;
        repeat (3) @(posedge sys_clk);
        #1 chk(rng_value[15:8], r[15:8], 8'hff);
        chk(rng_value[7:0], r[7:0], 8'hff);
        wr(`ADDR_CTRL_ONE, 8'h37);
        @(posedge sys_clk);
        #1 r = lfsr1(r);
        chk(rng_value[15:8], r[15:8], 8'hff);
        chk(rng_value[7:0], r[7:0], 8'hff);
        for (i = 0; i < `RNG_UNROLL; i = i + 1)
            r = lfsr1(r);
        @(posedge sys_clk);
        #1 chk(rng_value[15:8], r[15:8], 8'hff);
        chk(rng_value[7:0], r[7:0], 8'hff);
        rd(`ADDR_CTRL_ONE, 8'h00, 8'h0c);
        $display("register test done");
        // single-ended with and without a disabled input, then pairs, one single conversion, pin and timer triggers
        wr(`ADDR_CTRL_TWO, 8'h02);
        wr(`ADDR_CTRL_ONE, 8'h73);
        run(0, 2, 1'b1);
        en <= 8'hfd;
        wr(`ADDR_CTRL_ONE, 8'h73);
        run(0, 2, 1'b1);
        en <= 8'hff;
        wr(`ADDR_CTRL_TWO, 8'h09);
        wr(`ADDR_CTRL_ONE, 8'h73);
        run(8, 9, 1'b1);
        wr(`ADDR_CTRL_TWO, 8'h0d);
        wr(`ADDR_CTRL_ONE, 8'h73);
        run(13, 13, 1'b1);
        wr(`ADDR_CTRL_TWO, 8'h00);
        wr(`ADDR_CTRL_ONE, 8'h03);
        pin <= 1'b1;
        run(0, 0, 1'b0);
        pin <= 1'b0;
        wr(`ADDR_CTRL_ONE, 8'h23);
        tmr <= 1'b1;
        @(posedge sys_clk);
        tmr <= 1'b0;
        run(0, 0, 1'b0);
        // free-running mode last: a sequence may still be in flight
        wr(`ADDR_CTRL_TWO, 8'h0c);
        wr(`ADDR_CTRL_ONE, 8'h13);
        conv(4'hc, 1'b0);
        conv(4'hc, 1'b0);
        $display("trigger test done");
        summarize;
    end
endmodule
